//--- hdl/lad_pkg.sv
// Constants, types and carriers of the legacy address decoder
package lad_pkg;

    localparam int ADDR_W   = 36;
    localparam int LOW_W    = 20;
    localparam int HI_LSB   = 32;
    localparam int DATA_W   = 8;
    localparam int PORT_W   = 16;
    localparam int SEG_N    = 13;
    localparam int SEG_LSB  = 14;
    localparam int SEG_IW   = 6;
    localparam int PAGE_LSB = 16;

    // Compatibility area boundaries (low 20 address bits)
    localparam logic [LOW_W-1:0] DOS_TOP    = 20'h9FFFF;
    localparam logic [LOW_W-1:0] VGA_BASE   = 20'hA0000;
    localparam logic [LOW_W-1:0] PAGE_TOP   = 20'hAFFFF;
    localparam logic [LOW_W-1:0] MONO_BASE  = 20'hB0000;
    localparam logic [LOW_W-1:0] MONO_TOP   = 20'hB7FFF;
    localparam logic [LOW_W-1:0] VGA_TOP    = 20'hBFFFF;
    localparam logic [LOW_W-1:0] EXP_BASE   = 20'hC0000;
    localparam logic [SEG_IW-1:0] SEG_FIRST = 6'h30;
    localparam logic [3:0]        SBIOS_NIB = 4'hF;
    localparam logic [11:0]       MB_ZERO   = 12'h000;
    localparam logic [3:0]        HI_ZERO   = 4'h0;

    // I/O ports
    localparam logic [PORT_W-1:0] IDX_PORT   = 16'h03CE;
    localparam logic [PORT_W-1:0] DATA_PORT  = 16'h03CF;
    localparam logic [PORT_W-1:0] VIDIO_BASE = 16'h03B0;
    localparam logic [PORT_W-1:0] VIDIO_TOP  = 16'h03DF;
    localparam logic [PORT_W-1:0] MONO_P0    = 16'h03B4;
    localparam logic [PORT_W-1:0] MONO_P1    = 16'h03B5;
    localparam logic [PORT_W-1:0] MONO_P2    = 16'h03B8;
    localparam logic [PORT_W-1:0] MONO_P3    = 16'h03B9;
    localparam logic [PORT_W-1:0] MONO_P4    = 16'h03BA;
    localparam logic [PORT_W-1:0] MONO_P5    = 16'h03BF;

    // Indexed graphics registers
    localparam logic [DATA_W-1:0] IDX_MAP     = 8'h10;
    localparam logic [DATA_W-1:0] IDX_PAGE    = 8'h11;
    localparam logic [DATA_W-1:0] MAP_WMASK   = 8'h1F;
    localparam logic [DATA_W-1:0] REG_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;
    localparam int                MAP_PAGE_EN = 0;
    localparam int                MAP_DCACHE  = 4;
    localparam logic [SEG_N-1:0]  ATTR_RESET  = 13'h0000;
    localparam logic [ADDR_W-PAGE_LSB-DATA_W-1:0] DC_PAD = 12'h000;

    typedef enum logic [1:0] {
        SRC_CPU,
        SRC_HUB,
        SRC_AGP
    } lad_src_t;

    typedef enum logic [2:0] {
        TGT_DRAM,
        TGT_HUB,
        TGT_GFX,
        TGT_DCACHE,
        TGT_LOCAL,
        TGT_ABORT,
        TGT_REG
    } lad_tgt_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic              io;
        lad_src_t          src;
        logic              smm;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lad_req_t;

    typedef struct packed {
        logic              agp_on;
        logic              mono_adapter_decode;
        logic              bridge_command_reg_mem;
        logic              bridge_control_reg_vga;
        logic [1:0]        graphics_memory_select;
        logic              graphics_command_reg_mem;
        logic              secure_mode_ram_control_open;
    } lad_cfg_t;

    typedef struct packed {
        logic              valid;
        lad_tgt_t          target;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] rdata;
    } lad_rsp_t;

endpackage : lad_pkg

//--- hdl/lad_seg_attr.sv
// Per-segment read and write attribute lookup for C0000h-FFFFFh
`timescale 1ns/1ps
`default_nettype none
module lad_seg_attr
    import lad_pkg::*;
(
    input  wire logic [LOW_W-1:0] low_addr,
    input  wire logic             write,
    input  wire logic [SEG_N-1:0] rd_en,
    input  wire logic [SEG_N-1:0] wr_en,
    output logic      [SEG_N-1:0] seg_hit,
    output logic                  to_dram
);

    logic [SEG_N-1:0] seg_dram;

    // Twelve 16 KB segments then one 64 KB system segment
    for (genvar g = 0; g < SEG_N; g++) begin : g_seg
        if (g < SEG_N - 1) begin : g_small
            assign seg_hit[g] = (low_addr[LOW_W-1:SEG_LSB] == SEG_FIRST + SEG_IW'(g));
        end else begin : g_big
            assign seg_hit[g] = (low_addr[LOW_W-1:PAGE_LSB] == SBIOS_NIB);
        end
        assign seg_dram[g] = seg_hit[g] & (write ? wr_en[g] : rd_en[g]);
    end

    // Address is never remapped, a disabled segment simply leaves DRAM unreachable
    assign to_dram = |seg_dram;

endmodule : lad_seg_attr
`default_nettype wire

//--- hdl/lad_vga_steer.sv
// Target selection inside the video buffer region
`timescale 1ns/1ps
`default_nettype none
module lad_vga_steer
    import lad_pkg::*;
(
    input  wire lad_cfg_t  cfg,
    input  wire lad_src_t  src,
    input  wire logic      write,
    input  wire logic      smm,
    input  wire logic      in_page,
    input  wire logic      in_mono,
    input  wire logic      page_en,
    input  wire logic      page_dcache,
    output lad_tgt_t       tgt
);

    logic gfx_sel;
    logic smm_hit;
    logic mono_hub;
    logic page_hit;
    logic gfx_tgt;

    // Steering for processor and hub originators; graphics port originators are aborted
    assign gfx_sel  = cfg.agp_on
                    ? (cfg.bridge_command_reg_mem & cfg.bridge_control_reg_vga)
                    : ((|cfg.graphics_memory_select) & cfg.graphics_command_reg_mem);
    assign smm_hit  = smm & (src == SRC_CPU) & cfg.secure_mode_ram_control_open;
    assign mono_hub = cfg.agp_on & cfg.mono_adapter_decode & in_mono;
    assign page_hit = ~cfg.agp_on & gfx_sel & page_en & in_page;
    assign gfx_tgt  = gfx_sel & ~mono_hub;

    assign tgt = smm_hit                              ? TGT_DRAM
               : (src == SRC_AGP)                     ? TGT_ABORT
               : mono_hub                             ? TGT_HUB
               : page_hit                             ? (page_dcache ? TGT_DCACHE : TGT_GFX)
               : (gfx_tgt & (src == SRC_HUB) & ~write) ? TGT_ABORT
               : gfx_tgt                              ? TGT_GFX
               : TGT_HUB;

endmodule : lad_vga_steer
`default_nettype wire

//--- hdl/lad_decoder.sv
// Legacy address decoder top: routes memory and I/O cycles to their target
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Page selector picks the 64 KB display cache window under page mapping.
// - Page enable opens A0000h-AFFFFh; map bit 4 picks VGA buffer or display cache.
// - Accesses above 4 GB are claimed and ended locally, never sent to hub.
// - Above 4 GB writes drop data, reads return all zeros.
// - 000000h-09FFFFh always goes to main DRAM, no attributes.
// - Video buffer ignores attributes; steered to hub or graphics by configuration.
// - Video buffer is default SMM space, handled per secure RAM control.
// - Video steering applies to processor and hub originators.
// - Hub to graphics video buffer cycles support memory writes only, except A0000h-AFFFFh under page mapping.
// - Graphics port initiated video buffer accesses are master aborted.
// - Mono decode in AGP mode sends B0000h-B7FFFh to the hub.
// - Mono decode sends I/O ports 3B4h,3B5h,3B8h,3B9h,3BAh,3BFh to hub.
// - Expansion area is eight 16 KB segments with individual attributes.
// - Extended BIOS area is four 16 KB segments, DRAM or hub.
// - DRAM under a disabled segment is not relocated.
// - System BIOS segment resets read and write disabled, going to hub.
// - Thirteen ranges have separate read enable and write enable.
module lad_decoder
    import lad_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire lad_req_t         req,
    input  wire lad_cfg_t         cfg,
    input  wire logic [SEG_N-1:0] seg_rd_en,
    input  wire logic [SEG_N-1:0] seg_wr_en,
    output var  lad_rsp_t         rsp
);

    logic [DATA_W-1:0] idx_q;
    logic [DATA_W-1:0] idx_d;
    logic [DATA_W-1:0] map_q;
    logic [DATA_W-1:0] map_d;
    logic [DATA_W-1:0] page_q;
    logic [DATA_W-1:0] page_d;
    logic [SEG_N-1:0]  rd_en_q;
    logic [SEG_N-1:0]  wr_en_q;
    lad_rsp_t          rsp_q;
    lad_rsp_t          rsp_d;

    logic [LOW_W-1:0]  low_addr;
    logic [PORT_W-1:0] port;
    logic              addr_hi;
    logic              below_1m;
    logic              is_mem;
    logic              in_dos;
    logic              in_vga;
    logic              in_page;
    logic              in_mono;
    logic              in_compat;
    logic              io_idx;
    logic              io_data;
    logic              io_mono_port;
    logic              io_mono;
    logic              io_video;
    logic              seg_dram;
    logic [SEG_N-1:0]  seg_hit;
    lad_tgt_t          vga_tgt;
    lad_tgt_t          tgt;
    logic [ADDR_W-1:0] dc_addr;
    logic [DATA_W-1:0] reg_rdata;
    logic              wr_map;
    logic              wr_page;

    // Address classification
    assign low_addr  = req.addr[LOW_W-1:0];
    assign port      = req.addr[PORT_W-1:0];
    assign addr_hi   = (req.addr[ADDR_W-1:HI_LSB] != HI_ZERO);
    assign below_1m  = (req.addr[HI_LSB-1:LOW_W] == MB_ZERO);
    assign is_mem    = ~req.io & ~addr_hi & below_1m;
    assign in_dos    = is_mem & (low_addr <= DOS_TOP);
    assign in_vga    = is_mem & (low_addr >= VGA_BASE) & (low_addr <= VGA_TOP);
    assign in_page   = (low_addr >= VGA_BASE) & (low_addr <= PAGE_TOP);
    assign in_mono   = (low_addr >= MONO_BASE) & (low_addr <= MONO_TOP);
    assign in_compat = is_mem & (low_addr >= EXP_BASE);

    // I/O classification
    assign io_idx       = req.io & (port == IDX_PORT);
    assign io_data      = req.io & (port == DATA_PORT);
    assign io_mono_port = (port == MONO_P0) | (port == MONO_P1) | (port == MONO_P2)
                        | (port == MONO_P3) | (port == MONO_P4) | (port == MONO_P5);
    assign io_mono      = req.io & cfg.agp_on & cfg.mono_adapter_decode & io_mono_port;
    assign io_video     = req.io & cfg.agp_on & cfg.bridge_control_reg_vga
                        & (port >= VIDIO_BASE) & (port <= VIDIO_TOP);

    lad_vga_steer u_vga_steer (
        .cfg         (cfg),
        .src         (req.src),
        .write       (req.write),
        .smm         (req.smm),
        .in_page     (in_page),
        .in_mono     (in_mono),
        .page_en     (map_q[MAP_PAGE_EN]),
        .page_dcache (map_q[MAP_DCACHE]),
        .tgt         (vga_tgt)
    );

    lad_seg_attr u_seg_attr (
        .low_addr (low_addr),
        .write    (req.write),
        .rd_en    (rd_en_q),
        .wr_en    (wr_en_q),
        .seg_hit  (seg_hit),
        .to_dram  (seg_dram)
    );

    // Target priority: above 4 GB first, then registers, I/O, then memory regions
    assign tgt = addr_hi           ? TGT_LOCAL
               : (io_idx | io_data) ? TGT_REG
               : io_mono           ? TGT_HUB
               : io_video          ? TGT_GFX
               : req.io            ? TGT_HUB
               : in_dos            ? TGT_DRAM
               : in_vga            ? vga_tgt
               : in_compat         ? (seg_dram ? TGT_DRAM : TGT_HUB)
               : TGT_HUB;

    // Display cache address carries the page in place of the window base
    assign dc_addr = {DC_PAD, page_q, low_addr[PAGE_LSB-1:0]};

    assign reg_rdata = io_idx                ? idx_q
                     : (idx_q == IDX_MAP)    ? map_q
                     : (idx_q == IDX_PAGE)   ? page_q
                     : DATA_ZERO;

    // Register writes through the index and data ports
    assign wr_map  = req.valid & req.write & io_data & ~addr_hi & (idx_q == IDX_MAP);
    assign wr_page = req.valid & req.write & io_data & ~addr_hi & (idx_q == IDX_PAGE);
    assign idx_d   = (req.valid & req.write & io_idx & ~addr_hi) ? req.wdata : idx_q;
    assign map_d   = wr_map ? (req.wdata & MAP_WMASK) : map_q;
    assign page_d  = wr_page ? req.wdata : page_q;

    // Response word; local termination drops write data and reads zero
    assign rsp_d.valid  = req.valid;
    assign rsp_d.target = tgt;
    assign rsp_d.write  = req.write & (tgt != TGT_LOCAL) & (tgt != TGT_ABORT);
    assign rsp_d.addr   = (tgt == TGT_DCACHE) ? dc_addr : req.addr;
    assign rsp_d.rdata  = ((tgt == TGT_REG) & ~req.write) ? reg_rdata : DATA_ZERO;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            idx_q   <= REG_RESET;
            map_q   <= REG_RESET;
            page_q  <= REG_RESET;
            rd_en_q <= ATTR_RESET;
            wr_en_q <= ATTR_RESET;
            rsp_q   <= '0;
        end else if (ce) begin
            idx_q   <= idx_d;
            map_q   <= map_d;
            page_q  <= page_d;
            rd_en_q <= seg_rd_en;
            wr_en_q <= seg_wr_en;
            rsp_q   <= rsp_d;
        end
    end

    assign rsp = rsp_q;

    // Checks
    sequence s_take;
        rstn && ce && req.valid;
    endsequence

    sequence s_hi_req;
        s_take ##0 addr_hi;
    endsequence

    property p_hi_local;
        @(posedge clk) disable iff (!rstn)
        s_hi_req |=> (rsp_q.target == TGT_LOCAL) && (rsp_q.rdata == DATA_ZERO) && !rsp_q.write;
    endproperty
    a_hi_local: assert property (p_hi_local) else $error("above 4 GB not ended locally");

    property p_hi_no_reg;
        @(posedge clk) disable iff (!rstn)
        (s_hi_req ##0 req.write) |=> $stable(page_q) && $stable(map_q);
    endproperty
    a_hi_no_reg: assert property (p_hi_no_reg) else $error("above 4 GB write changed state");

    property p_dos;
        @(posedge clk) disable iff (!rstn)
        (s_take ##0 in_dos) |=> rsp_q.target == TGT_DRAM;
    endproperty
    a_dos: assert property (p_dos) else $error("DOS cycle not sent to DRAM");

    property p_dcache;
        @(posedge clk) disable iff (!rstn)
        (s_take ##0 (in_vga && in_page && !req.smm && req.src == SRC_CPU && !cfg.agp_on
         && (|cfg.graphics_memory_select) && cfg.graphics_command_reg_mem
         && map_q[MAP_PAGE_EN] && map_q[MAP_DCACHE]))
        |=> rsp_q.target == TGT_DCACHE
            && rsp_q.addr[PAGE_LSB+DATA_W-1:PAGE_LSB] == $past(page_q)
            && rsp_q.addr[PAGE_LSB-1:0] == $past(low_addr[PAGE_LSB-1:0]);
    endproperty
    a_dcache: assert property (p_dcache) else $error("display cache page not applied");

    property p_page_write;
        @(posedge clk) disable iff (!rstn)
        (s_take ##0 wr_page) |=> page_q == $past(req.wdata);
    endproperty
    a_page_write: assert property (p_page_write) else $error("page selector not written");

    property p_mono_mem;
        @(posedge clk) disable iff (!rstn)
        (s_take ##0 (in_vga && in_mono && cfg.agp_on && cfg.mono_adapter_decode
         && req.src == SRC_CPU && !req.smm)) |=> rsp_q.target == TGT_HUB;
    endproperty
    a_mono_mem: assert property (p_mono_mem) else $error("mono memory not sent to hub");

    property p_mono_io;
        @(posedge clk) disable iff (!rstn)
        (s_take ##0 io_mono && !addr_hi) |=> rsp_q.target == TGT_HUB;
    endproperty
    a_mono_io: assert property (p_mono_io) else $error("mono I/O not sent to hub");

    property p_agp_abort;
        @(posedge clk) disable iff (!rstn)
        (s_take ##0 (in_vga && req.src == SRC_AGP)) |=> rsp_q.target == TGT_ABORT;
    endproperty
    a_agp_abort: assert property (p_agp_abort) else $error("graphics port VGA not aborted");

    property p_hub_gfx_write;
        @(posedge clk) disable iff (!rstn)
        (s_take ##0 (in_vga && req.src == SRC_HUB)) |=> rsp_q.target != TGT_GFX || rsp_q.write;
    endproperty
    a_hub_gfx_write: assert property (p_hub_gfx_write) else $error("hub read reached graphics");

    property p_sbios_reset;
        @(posedge clk)
        (!rstn ##1 (s_take ##0 (in_compat && seg_hit[SEG_N-1]))) |=> rsp_q.target == TGT_HUB;
    endproperty
    a_sbios_reset: assert property (p_sbios_reset) else $error("BIOS segment not disabled at reset");

    property p_seg_read;
        @(posedge clk) disable iff (!rstn)
        (s_take ##0 (in_compat && !req.write && |(seg_hit & rd_en_q))) |=> rsp_q.target == TGT_DRAM;
    endproperty
    a_seg_read: assert property (p_seg_read) else $error("enabled segment read not to DRAM");

    property p_seg_write_off;
        @(posedge clk) disable iff (!rstn)
        (s_take ##0 (in_compat && req.write && !(|(seg_hit & wr_en_q))))
        |=> rsp_q.target == TGT_HUB && rsp_q.addr == $past(req.addr);
    endproperty
    a_seg_write_off: assert property (p_seg_write_off) else $error("disabled segment misrouted");

endmodule : lad_decoder
`default_nettype wire

//--- sim/lad_host_model.sv
// Requester model standing on the processor, hub and graphics side of the decoder
`timescale 1ns/1ps
`default_nettype none
module lad_host_model
    import lad_pkg::*;
(
    input  wire logic     clk,
    output var  lad_req_t req
);
    initial req = '0;

    // One cycle per call; valid drops on the next edge, so no two requests overlap
    task automatic issue(input logic wr, input logic io, input lad_src_t src, input logic smm,
                         input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        req <= '{valid: 1'b1, write: wr, io: io, src: src, smm: smm, addr: a, wdata: d};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
    endtask : issue
endmodule : lad_host_model
`default_nettype wire

//--- sim/legacy_address_decoder_tb.sv
// Self-checking testbench of the legacy address decoder
`timescale 1ns/1ps
`default_nettype none
module legacy_address_decoder_tb;
    import lad_pkg::*;
    logic             clk = 1'b0;
    logic             rstn = 1'b0;
    logic             ce = 1'b1;
    lad_req_t         req;
    lad_cfg_t         cfg = '0;
    logic [SEG_N-1:0] seg_rd_en = '0;
    logic [SEG_N-1:0] seg_wr_en = '0;
    lad_rsp_t         rsp;
    int               fail_count = 0;
    int               samples_checked = 0;

    always #2 clk = ~clk;

    lad_host_model host_u (.clk(clk), .req(req));
    lad_decoder dut_u (.clk(clk), .rstn(rstn), .ce(ce), .req(req), .cfg(cfg),
                       .seg_rd_en(seg_rd_en), .seg_wr_en(seg_wr_en), .rsp(rsp));

    task automatic check_tgt(input lad_tgt_t exp);
        samples_checked++;
        if (rsp.target !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t target %0d expected %0d", $time, rsp.target, exp);
        end
    endtask : check_tgt

    task automatic check_bits(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
        end
    endtask : check_bits

    task automatic go(input logic wr, input logic io, input lad_src_t src, input logic smm,
                      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input lad_tgt_t e);
        host_u.issue(wr, io, src, smm, a, d);
        check_bits(ADDR_W'(rsp.valid), ADDR_W'(1'b1));
        check_tgt(e);
        check_bits(ADDR_W'(rsp.write), ADDR_W'(wr & (e != TGT_LOCAL) & (e != TGT_ABORT)));
        check_bits(ADDR_W'(rsp.rdata), ADDR_W'(wr ? DATA_ZERO : d));
        if (e != TGT_DCACHE) begin
            check_bits(rsp.addr, a);
        end
    endtask : go

    task automatic mem(input logic wr, input lad_src_t s, input logic [19:0] a, input lad_tgt_t e);
        go(wr, 1'b0, s, 1'b0, {16'h0000, a}, DATA_ZERO, e);
    endtask : mem

    task automatic io(input logic wr, input logic [15:0] p, input logic [7:0] d, input lad_tgt_t e);
        go(wr, 1'b1, SRC_CPU, 1'b0, {20'h00000, p}, d, e);
    endtask : io

    // Bits: agp_on, mono, bridge mem, bridge vga, select[1:0], graphics mem, secure open
    task automatic set_cfg(input logic [7:0] c);
        @(posedge clk);
        cfg <= lad_cfg_t'(c);
        @(posedge clk);
    endtask : set_cfg

    task automatic set_attr(input logic [SEG_N-1:0] r, input logic [SEG_N-1:0] w);
        @(posedge clk);
        seg_rd_en <= r;
        seg_wr_en <= w;
        @(posedge clk);
    endtask : set_attr

    // First request is launched on the edge that releases reset
    task automatic t_reset();
        #1;
        check_bits(ADDR_W'(rsp.valid), ADDR_W'(1'b0));
        mem(1'b0, SRC_CPU, 20'hF0000, TGT_HUB);
        mem(1'b1, SRC_CPU, 20'hFFFFF, TGT_HUB);
        mem(1'b0, SRC_CPU, 20'hC0000, TGT_HUB);
    endtask : t_reset

    task automatic t_high();
        go(1'b1, 1'b0, SRC_CPU, 1'b0, 36'h1_0000_0000, 8'hA5, TGT_LOCAL);
        go(1'b0, 1'b0, SRC_CPU, 1'b0, 36'hF_FFFF_FFFF, DATA_ZERO, TGT_LOCAL);
        go(1'b0, 1'b0, SRC_CPU, 1'b0, 36'h0_FFFF_FFFF, DATA_ZERO, TGT_HUB);
    endtask : t_high

    task automatic t_dos();
        set_attr('0, '0);
        mem(1'b0, SRC_CPU, 20'h00000, TGT_DRAM);
        mem(1'b1, SRC_HUB, 20'h9FFFF, TGT_DRAM);
        set_attr('1, '1);
        mem(1'b0, SRC_CPU, 20'h9FFFF, TGT_DRAM);
    endtask : t_dos

    task automatic t_segs();
        logic [19:0] base;
        logic [19:0] top;
        for (int i = 0; i < SEG_N; i++) begin
            base = EXP_BASE + 20'(i) * 20'h04000;
            top = (i == SEG_N - 1) ? 20'hFFFFF : base + 20'h03FFF;
            set_attr(13'h0001 << i, '0);
            mem(1'b0, SRC_CPU, base, TGT_DRAM);
            mem(1'b1, SRC_CPU, top, TGT_HUB);
            mem(1'b0, SRC_CPU, (i == SEG_N - 1) ? base - 20'h1 : top + 20'h1, TGT_HUB);
            set_attr('0, 13'h0001 << i);
            mem(1'b1, SRC_CPU, top, TGT_DRAM);
            mem(1'b0, SRC_CPU, base, TGT_HUB);
        end
    endtask : t_segs

    task automatic t_vga();
        set_attr('1, '1);
        set_cfg(8'h00);
        mem(1'b0, SRC_CPU, 20'hA0000, TGT_HUB);
        mem(1'b1, SRC_CPU, 20'hBFFFF, TGT_HUB);
        set_cfg(8'hB0);
        mem(1'b0, SRC_CPU, 20'hA0000, TGT_GFX);
        mem(1'b1, SRC_HUB, 20'hB8000, TGT_GFX);
        mem(1'b0, SRC_HUB, 20'hB8000, TGT_ABORT);
        mem(1'b0, SRC_AGP, 20'hA0000, TGT_ABORT);
        mem(1'b1, SRC_AGP, 20'hBFFFF, TGT_ABORT);
        set_cfg(8'hB1);
        go(1'b0, 1'b0, SRC_CPU, 1'b1, 36'h0_000A_0000, DATA_ZERO, TGT_DRAM);
        go(1'b0, 1'b0, SRC_CPU, 1'b0, 36'h0_000A_0000, DATA_ZERO, TGT_GFX);
        set_cfg(8'h06);
        mem(1'b0, SRC_CPU, 20'hB0000, TGT_GFX);
    endtask : t_vga

    task automatic t_mono();
        logic [15:0] ports [6];
        ports = '{MONO_P0, MONO_P1, MONO_P2, MONO_P3, MONO_P4, MONO_P5};
        set_cfg(8'hF0);
        mem(1'b0, SRC_CPU, 20'hB0000, TGT_HUB);
        mem(1'b1, SRC_CPU, 20'hB7FFF, TGT_HUB);
        mem(1'b0, SRC_CPU, 20'hB8000, TGT_GFX);
        foreach (ports[i]) begin
            io(1'b1, ports[i], DATA_ZERO, TGT_HUB);
        end
        io(1'b0, 16'h03B6, DATA_ZERO, TGT_GFX);
    endtask : t_mono

    task automatic t_page();
        set_cfg(8'h06);
        io(1'b1, IDX_PORT, IDX_MAP, TGT_REG);
        io(1'b1, DATA_PORT, 8'hF1, TGT_REG);
        io(1'b0, DATA_PORT, 8'h11, TGT_REG);
        io(1'b1, IDX_PORT, IDX_PAGE, TGT_REG);
        io(1'b0, DATA_PORT, REG_RESET, TGT_REG);
        io(1'b1, DATA_PORT, 8'hFF, TGT_REG);
        io(1'b0, DATA_PORT, 8'hFF, TGT_REG);
        go(1'b1, 1'b1, SRC_CPU, 1'b0, 36'h1_0000_03CF, DATA_ZERO, TGT_LOCAL);
        io(1'b0, DATA_PORT, 8'hFF, TGT_REG);
        mem(1'b0, SRC_CPU, 20'hA1234, TGT_DCACHE);
        check_bits(rsp.addr, {DC_PAD, 8'hFF, 16'h1234});
        mem(1'b1, SRC_CPU, 20'hAFFFF, TGT_DCACHE);
        check_bits(rsp.addr, {DC_PAD, 8'hFF, 16'hFFFF});
        io(1'b1, IDX_PORT, IDX_MAP, TGT_REG);
        io(1'b1, DATA_PORT, 8'h01, TGT_REG);
        mem(1'b0, SRC_CPU, 20'hA1234, TGT_GFX);
    endtask : t_page

    // Clock enable low must ignore a register write and hold the response
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        host_u.issue(1'b1, 1'b1, SRC_CPU, 1'b0, {20'h00000, IDX_PORT}, IDX_PAGE);
        check_bits(ADDR_W'(rsp.valid), ADDR_W'(1'b0));
        @(posedge clk);
        ce <= 1'b1;
        io(1'b0, IDX_PORT, IDX_MAP, TGT_REG);
    endtask : t_freeze

    task automatic wrap_up();
        $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
    end

    initial begin
        repeat (7) @(posedge clk);
        t_reset();
        t_high();
        t_dos();
        t_segs();
        t_vga();
        t_mono();
        t_page();
        t_freeze();
        wrap_up();
    end

    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
endmodule : legacy_address_decoder_tb
`default_nettype wire
